// file: core/stm_pkg.sv
// Shared constants and types for the dual-channel torque-off monitor
// ****************************************************************
// Notes on behaviour
// - Shutoff starts from the inputs alone, whether or not the host issues commands.
// - A suspended utility resumes only after exit and re-entry on both axes.
// - In shutoff, servo-on is refused and servo-ready is held low.
// - Servo-ready only with both inputs ON and the servo off.
// - Ready and shutoff behaviour apply to axis A and B together.
// - Either input going OFF drops the brake-release output at once.
// - Shutoff brake drop ignores the configured brake-off delay.
// - Shutoff stops the motor by the configured servo-off stop mode.
// - Stop modes 0 and 1 select the dynamic brake.
// - Alarm output is held low while in shutoff.
// - Feedback output is ON only when both inputs are OFF.
// - Feedback turns ON within 8 ms of both inputs going OFF.
// - With both inputs OFF, show shutoff indication and stop both motors.
// - Open connector means no current, no torque, shutoff indication.
// - OFF pulses of 0.5 ms or less are ignored.
// - One input alone changed for 10 s raises a latched timing alarm.
// - Servo-on during OFF keeps shutoff until servo-off on both axes.
// - Shutoff sets emergency-stop status; shutoff during motion warns.
// ****************************************************************
package stm_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint CLK_HZ         = 64'd25_000_000;
  localparam longint FILT_TIME_US   = 64'd500;
  localparam longint FILT_CYC       = (FILT_TIME_US * CLK_HZ + 64'd999_999) / 64'd1_000_000;
  localparam longint SKEW_TIME_S    = 64'd10;
  localparam longint SKEW_CYC       = SKEW_TIME_S * CLK_HZ;
  localparam longint FDBK_TIME_US   = 64'd8000;
  localparam longint FDBK_MAX_CYC   = (FDBK_TIME_US * CLK_HZ) / 64'd1_000_000;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [3:0] ADDR_CMD    = 4'h0;
  localparam logic [3:0] ADDR_CFG    = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_WARN   = 4'hc;

  // Command bits (write pulses)
  localparam int CMD_SON   = 0;
  localparam int CMD_SOFF  = 2;
  localparam int CMD_UENT  = 4;
  localparam int CMD_UEXIT = 6;

  // Configuration fields
  localparam int CFG_STOP_LSB   = 0;
  localparam int CFG_MOTION_LSB = 8;
  localparam int CFG_DELAY_LSB  = 16;
  localparam logic [3:0]  STOP_MODE_RST  = 4'h0;
  localparam logic [15:0] BRK_DELAY_RST  = 16'h0000;
  localparam logic [3:0]  STOP_DB_HOLD   = 4'h0;
  localparam logic [3:0]  STOP_DB_FREE   = 4'h1;

  // ****************************************************************
  // Bus carriers
  // ****************************************************************
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } stm_avs_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } stm_avs_rsp_type;

endpackage : stm_pkg

// file: core/stm_monitor.sv
// Dual-channel torque-off monitor with Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none

module stm_monitor #(
  parameter int unsigned FILT_CYC_P = 32'(stm_pkg::FILT_CYC),
  parameter int unsigned SKEW_CYC_P = 32'(stm_pkg::SKEW_CYC)
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_shutoff_in_a_n,
  input  wire logic                     i_shutoff_in_b_n,
  input  wire logic [1:0]               i_motor_stopped,
  input  wire logic                     i_drive_fault,
  input  wire stm_pkg::stm_avs_req_type i_avs,
  output var  stm_pkg::stm_avs_rsp_type o_avs,
  output logic                          o_shutoff_feedback_out,
  output logic [1:0]                    o_brake_release_out,
  output logic                          o_servo_alarm_out,
  output logic [1:0]                    o_servo_ready,
  output logic [1:0]                    o_gate_enable,
  output logic [1:0]                    o_dyn_brake,
  output logic [1:0]                    o_util_active,
  output logic                          o_shutoff_display
);

  localparam logic [13:0] FILT_LIM = 14'(FILT_CYC_P);
  localparam logic [27:0] SKEW_LIM = 28'(SKEW_CYC_P);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0][2:0]  sync;
    logic [1:0]       on;
    logic [1:0][13:0] filt_cnt;
    logic [27:0]      skew_cnt;
    logic             timing_alarm;
    logic             hold;
    logic [1:0]       off_seen;
    logic [1:0]       servo_on;
    logic [1:0][15:0] brk_cnt;
    logic [1:0]       brake;
    logic [1:0]       dynb;
    logic [1:0]       gate;
    logic [1:0]       ready;
    logic [1:0]       util_run;
    logic             util_susp;
    logic [1:0]       util_exited;
    logic [1:0]       util_reent;
    logic [1:0]       util_act;
    logic [1:0]       warn;
    logic             prev_shut;
    logic [3:0]       stop_mode;
    logic [15:0]      brk_delay;
    logic [1:0]       motion;
    logic             feedback;
    logic             alarm;
    logic             display;
    logic             waitreq;
    logic [31:0]      rdata;
  } stm_state_type;

  stm_state_type q;
  stm_state_type d;

  localparam stm_state_type STATE_RST = '{
    sync:        '0,
    on:          2'h0,
    filt_cnt:    '0,
    skew_cnt:    28'h0000000,
    timing_alarm: 1'b0,
    hold:        1'b0,
    off_seen:    2'h0,
    servo_on:    2'h0,
    brk_cnt:     '0,
    brake:       2'h0,
    dynb:        2'h0,
    gate:        2'h0,
    ready:       2'h0,
    util_run:    2'h0,
    util_susp:   1'b0,
    util_exited: 2'h0,
    util_reent:  2'h0,
    util_act:    2'h0,
    warn:        2'h0,
    prev_shut:   1'b1,
    stop_mode:   stm_pkg::STOP_MODE_RST,
    brk_delay:   stm_pkg::BRK_DELAY_RST,
    motion:      2'h0,
    feedback:    1'b0,
    alarm:       1'b0,
    display:     1'b1,
    waitreq:     1'b1,
    rdata:       32'h00000000
  };

  // Merge write data into a word under the byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : be_merge

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic        wr_take;
    logic        rd_start;
    logic [7:0]  cmd;
    logic        shut_raw;
    logic        shut_eff;
    logic        shut_rise;
    logic        alarm_any;
    logic [31:0] cfg_word;
    logic [31:0] cfg_new;
    logic [31:0] status_word;

    d = q;
    shut_raw    = 1'b0;
    shut_eff    = 1'b0;
    shut_rise   = 1'b0;
    alarm_any   = 1'b0;
    status_word = 32'h00000000;
    wr_take  = i_avs.write && !q.waitreq;
    rd_start = i_avs.read && q.waitreq;
    cmd      = 8'h00;
    cfg_word = {q.brk_delay, 6'h00, q.motion, 4'h0, q.stop_mode};
    cfg_new  = be_merge(cfg_word, i_avs.writedata, i_avs.byteenable);

    // Bus write side effects, taken at the edge that completes the transfer, one cycle after the wait
    if (wr_take && i_avs.byteenable[0]) begin
      if (i_avs.address == stm_pkg::ADDR_CMD) begin
        cmd = i_avs.writedata[7:0];
      end
    end
    // Configuration takes effect at the edge that completes the write
    if (wr_take && (i_avs.address == stm_pkg::ADDR_CFG)) begin
      d.stop_mode = cfg_new[stm_pkg::CFG_STOP_LSB +: 4];
      d.motion    = cfg_new[stm_pkg::CFG_MOTION_LSB +: 2];
      d.brk_delay = cfg_new[stm_pkg::CFG_DELAY_LSB +: 16];
    end

    // Three-stage pin chain; only stages two and three are compared
    // Stage one is never compared, so a metastable value cannot reach the filter
    d.sync[0] = {q.sync[0][1:0], i_shutoff_in_a_n};
    d.sync[1] = {q.sync[1][1:0], i_shutoff_in_b_n};
    // The count restarts only on an agreed high; a one-cycle split leaves it alone
    for (int c = 0; c < 2; c++) begin
      if (q.sync[c][1] == q.sync[c][2]) begin
        if (q.sync[c][2]) begin
          d.on[c]       = 1'b1;
          d.filt_cnt[c] = 14'h0000;
        end else if (q.filt_cnt[c] == FILT_LIM) begin
          d.on[c] = 1'b0;
        end else begin
          d.filt_cnt[c] = q.filt_cnt[c] + 14'h0001;
        end
      end
    end

    // One channel alone for too long: latched until power reset
    // No software clear: a broken wire must not be hidden by a register write
    if (q.on[0] != q.on[1]) begin
      if (q.skew_cnt == SKEW_LIM) begin
        d.timing_alarm = 1'b1;
      end else begin
        d.skew_cnt = q.skew_cnt + 28'h0000001;
      end
    end else begin
      d.skew_cnt = 28'h0000000;
    end

    // Shutoff does not look at any command: host presence is irrelevant
    shut_raw  = !q.on[0] || !q.on[1];
    alarm_any = q.timing_alarm || i_drive_fault;

    // Servo-on refused during shutoff latches the hold
    if (q.hold && (&q.off_seen) && !shut_raw) begin
      d.hold     = 1'b0;
      d.off_seen = 2'h0;
    end else if (q.hold) begin
      d.off_seen = q.off_seen | cmd[stm_pkg::CMD_SOFF +: 2];
    end
    // Set needs raw shutoff, which blocks the clear, so a servo-on in the clearing cycle does not keep the hold
    if (shut_raw && (|cmd[stm_pkg::CMD_SON +: 2])) begin
      d.hold = 1'b1;
    end
    shut_eff  = shut_raw || q.hold;
    shut_rise = shut_eff && !q.prev_shut;
    d.prev_shut = shut_eff;

    // Per-axis servo, brake and stop logic, common to both axes
    for (int ax = 0; ax < 2; ax++) begin
      if (shut_eff || cmd[stm_pkg::CMD_SOFF + ax]) begin
        d.servo_on[ax] = 1'b0;
      end else if (cmd[stm_pkg::CMD_SON + ax] && !alarm_any) begin
        d.servo_on[ax] = 1'b1;
      end
      if (alarm_any) begin
        d.servo_on[ax] = 1'b0;
      end

      // Shutoff drops the brake at once; the delay only serves servo-off
      if (shut_eff || alarm_any) begin
        d.brake[ax]   = 1'b0;
        d.brk_cnt[ax] = 16'h0000;
      end else if (d.servo_on[ax]) begin
        d.brake[ax]   = 1'b1;
        d.brk_cnt[ax] = q.brk_delay;
      end else if (q.brake[ax]) begin
        if (q.brk_cnt[ax] == 16'h0000) begin
          d.brake[ax] = 1'b0;
        end else begin
          d.brk_cnt[ax] = q.brk_cnt[ax] - 16'h0001;
        end
      end

      // Same stop mode for shutoff as for ordinary servo-off
      // Codes above one let the motor coast
      if (d.servo_on[ax]) begin
        d.dynb[ax] = 1'b0;
      end else if (q.stop_mode == stm_pkg::STOP_DB_HOLD) begin
        d.dynb[ax] = 1'b1;
      end else if (q.stop_mode == stm_pkg::STOP_DB_FREE) begin
        d.dynb[ax] = !i_motor_stopped[ax];
      end else begin
        d.dynb[ax] = 1'b0;
      end

      // Gate repeats the shutoff term so current stays cut even if servo-on sticks
      d.gate[ax]  = d.servo_on[ax] && !shut_eff;
      d.ready[ax] = !shut_eff && !d.servo_on[ax] && !alarm_any;

      // Warning flag: a new event wins over a clear in the same cycle
      if (wr_take && (i_avs.address == stm_pkg::ADDR_WARN) && i_avs.byteenable[0] &&
          i_avs.writedata[ax]) begin
        d.warn[ax] = 1'b0;
      end
      if (shut_rise && q.motion[ax]) begin
        d.warn[ax] = 1'b1;
      end

      // Utility run flags
      // Exit and entry count only while suspended; earlier presses do not
      if (cmd[stm_pkg::CMD_UEXIT + ax]) begin
        d.util_run[ax] = 1'b0;
      end else if (cmd[stm_pkg::CMD_UENT + ax]) begin
        d.util_run[ax] = 1'b1;
      end
      if (q.util_susp && cmd[stm_pkg::CMD_UEXIT + ax]) begin
        d.util_exited[ax] = 1'b1;
      end
      if (q.util_susp && q.util_exited[ax] && cmd[stm_pkg::CMD_UENT + ax]) begin
        d.util_reent[ax] = 1'b1;
      end
    end

    // Suspension lifts only after both axes left and re-entered
    if (q.util_susp && (&q.util_reent) && !shut_eff) begin
      d.util_susp   = 1'b0;
      d.util_exited = 2'h0;
      d.util_reent  = 2'h0;
    end
    if (shut_rise && (|q.util_run)) begin
      d.util_susp   = 1'b1;
      d.util_exited = 2'h0;
      d.util_reent  = 2'h0;
    end
    d.util_act = d.util_run & {2{!d.util_susp && !shut_eff}};

    // Feedback follows the filtered pair; worst lag is filter plus chain
    d.feedback = !q.on[0] && !q.on[1];
    d.alarm    = alarm_any && !shut_eff;
    d.display  = shut_eff;

    // Status word, built from registers so a read never sees a half-updated pair
    status_word[1:0]   = q.on;
    status_word[2]     = shut_eff;
    status_word[3]     = q.feedback;
    status_word[4]     = q.timing_alarm;
    status_word[5]     = q.hold;
    status_word[6]     = q.util_susp;
    status_word[9:8]   = q.servo_on;
    status_word[11:10] = {2{shut_eff}};
    status_word[13:12] = q.ready;
    status_word[15:14] = q.brake;
    status_word[17:16] = q.dynb;

    // ****************************************************************
    // Avalon slave: one wait cycle, then the answer
    // ****************************************************************
    // The wait state gives the read mux a whole cycle; each access costs two
    if ((i_avs.read || i_avs.write) && q.waitreq) begin
      d.waitreq = 1'b0;
    end else begin
      d.waitreq = 1'b1;
    end
    if (rd_start) begin
      unique case (i_avs.address)
        stm_pkg::ADDR_CFG:    d.rdata = cfg_word;
        stm_pkg::ADDR_STATUS: d.rdata = status_word;
        stm_pkg::ADDR_WARN:   d.rdata = {30'h00000000, q.warn};
        default:              d.rdata = 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Reset leaves the drive in shutoff until both pins are seen ON
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Every output is a register bit; no logic sits between the state and a pin
  assign o_avs                = '{readdata: q.rdata, waitrequest: q.waitreq};
  assign o_shutoff_feedback_out = q.feedback;
  assign o_brake_release_out  = q.brake;
  assign o_servo_alarm_out    = q.alarm;
  assign o_servo_ready        = q.ready;
  assign o_gate_enable        = q.gate;
  assign o_dyn_brake          = q.dynb;
  assign o_util_active        = q.util_act;
  assign o_shutoff_display    = q.display;

endmodule : stm_monitor

`default_nettype wire

// file: test/stm_monitor_properties.sv
// Port checker for the torque-off monitor
`timescale 1ns/100ps
`default_nettype none
module stm_monitor_chk #(
  parameter int unsigned FILT_CYC_P = 20
) (
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic       i_shutoff_in_a_n,
  input wire logic       i_shutoff_in_b_n,
  input wire logic       o_shutoff_feedback_out,
  input wire logic [1:0] o_brake_release_out,
  input wire logic       o_servo_alarm_out,
  input wire logic [1:0] o_servo_ready,
  input wire logic [1:0] o_gate_enable,
  input wire logic       o_shutoff_display
);
  // ****
  // Low-run counters saturate so a long shutoff cannot wrap them
  // ****
  logic [15:0] la_q;
  logic [15:0] lb_q;
  logic        lng_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      la_q  <= '0;
      lb_q  <= '0;
      lng_q <= 1'b0;
    end else begin
      la_q  <= i_shutoff_in_a_n ? '0 : ((&la_q) ? la_q : la_q + 16'h1);
      lb_q  <= i_shutoff_in_b_n ? '0 : ((&lb_q) ? lb_q : lb_q + 16'h1);
      lng_q <= (la_q >= FILT_CYC_P) | (lb_q >= FILT_CYC_P) | (lng_q & !o_shutoff_display);
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  sequence s_trip;
    $rose(o_shutoff_display) && $past(i_rst_b, 8);
  endsequence
  property p_trip_brake;
    s_trip |-> ##[0:1] (o_brake_release_out == 2'b00);
  endproperty
  a_trip_brake: assert property (p_trip_brake) else $error("brake kept at shutoff");
  property p_trip_long;
    s_trip |-> lng_q;
  endproperty
  a_trip_long: assert property (p_trip_long) else $error("short pulse tripped");
  property p_gate_off;
    o_shutoff_display [*2] |-> (o_gate_enable == 2'b00) && (o_servo_ready == 2'b00);
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("drive live in shutoff");
  property p_quiet;
    o_shutoff_display [*2] |-> !o_servo_alarm_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("alarm shown in shutoff");
  property p_ready_idle;
    (o_servo_ready != 2'b00) |-> ((o_servo_ready & o_gate_enable) == 2'b00) &&
      !o_shutoff_display && !o_servo_alarm_out;
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("ready while servo on");
  property p_fb_cause;
    $rose(o_shutoff_feedback_out) && $past(i_rst_b, 8)
      |-> !$past(i_shutoff_in_a_n, 4) && !$past(i_shutoff_in_b_n, 4);
  endproperty
  a_fb_cause: assert property (p_fb_cause) else $error("feedback without both off");
  property p_fb_drop;
    (i_shutoff_in_a_n || i_shutoff_in_b_n) [*8] |-> !o_shutoff_feedback_out;
  endproperty
  a_fb_drop: assert property (p_fb_drop) else $error("feedback with an input on");
  property p_fb_time;
    (la_q >= FILT_CYC_P + 8) && (lb_q >= FILT_CYC_P + 8) |-> o_shutoff_feedback_out;
  endproperty
  a_fb_time: assert property (p_fb_time) else $error("feedback late");
endmodule : stm_monitor_chk
`default_nettype wire

// file: test/stm_safety_ctrl.sv
// Safety controller model driving both shutoff pins
`timescale 1ns/100ps
`default_nettype none
module stm_safety_ctrl (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic [1:0] i_want_on,
  input  wire logic       i_feedback,
  output logic [1:0]      o_pin_n,
  output logic            o_fail
);
  logic seen_q;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pin_n <= 2'b00;  // Power up with the guard open
      seen_q  <= 1'b0;
      o_fail  <= 1'b0;
    end else begin
      seen_q <= (o_pin_n == 2'b00) & (seen_q | i_feedback);
      if (o_pin_n == 2'b00 && i_want_on != 2'b00 && !seen_q) begin
        o_fail <= 1'b1;  // No release without seen feedback
      end else begin
        o_pin_n <= i_want_on;
      end
    end
  end
endmodule : stm_safety_ctrl
`default_nettype wire

// file: test/test_stm_monitor.sv
// Self-checking bench for the torque-off monitor
`timescale 1ns/100ps
`default_nettype none
module test_stm_monitor;
  localparam int unsigned FP = 20;
  localparam int unsigned SP = 200;
  logic                     i_clk   = 1'b0;
  logic                     i_rst_b = 1'b0;
  logic [1:0]               want    = 2'b00;
  logic [1:0]               stopped = 2'b00;
  logic                     fault   = 1'b0;
  stm_pkg::stm_avs_req_type avs     = '0;
  stm_pkg::stm_avs_rsp_type rsp;
  logic [1:0]               pin_n, brk, rdy, gate, dyn, util;
  logic                     fail, fb, servo_alarm_out, disp;
  logic [31:0]              exp_q[$], msk_q[$];
  int                       err_total = 0;
  int                       n_compared = 0;
  always #20 i_clk = ~i_clk;
  stm_safety_ctrl u_stm_safety_ctrl (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_want_on(want),
    .i_feedback(fb), .o_pin_n(pin_n), .o_fail(fail));
  stm_monitor #(.FILT_CYC_P(FP), .SKEW_CYC_P(SP)) u_stm_monitor (.i_clk(i_clk),
    .i_rst_b(i_rst_b), .i_shutoff_in_a_n(pin_n[0]), .i_shutoff_in_b_n(pin_n[1]),
    .i_motor_stopped(stopped), .i_drive_fault(fault), .i_avs(avs), .o_avs(rsp),
    .o_shutoff_feedback_out(fb), .o_brake_release_out(brk), .o_servo_alarm_out(servo_alarm_out),
    .o_servo_ready(rdy), .o_gate_enable(gate), .o_dyn_brake(dyn), .o_util_active(util),
    .o_shutoff_display(disp));
  // ****
  // Shared tasks
  // ****
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    avs <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: 4'hf};
    @(posedge i_clk);
    while (rsp.waitrequest !== 1'b0) begin
      @(posedge i_clk);
      n++;
    end
    check("wait_states", 32'(n), 32'h1);
    avs.read  <= 1'b0;
    avs.write <= 1'b0;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic pause(input int n);
    repeat (n) @(posedge i_clk);
  endtask : pause
  task automatic wdisp(input logic v);
    int n;
    n = 0;
    while (disp !== v && n < 200) begin
      @(posedge i_clk);
      n++;
    end
    check("display", 32'(disp), 32'(v));
  endtask : wdisp
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // Read data are matched against the oldest note as each read completes
  always @(posedge i_clk) begin
    if (avs.read && rsp.waitrequest === 1'b0 && exp_q.size() > 0) begin
      check("readdata", rsp.readdata & msk_q[0], exp_q[0]);
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  initial begin
    pause(5000);
    check("watchdog", 32'h1, 32'h0);
    report_and_stop();
  end
  initial begin
    int len;
    logic [1:0] st, ed;
    void'($urandom(32'h0d18));
    pause(2);
    i_rst_b <= 1'b1;
    pause(FP + 10);
    rd(4'h8, 32'h3f, 32'h0c);
    wdisp(1'b1);
    check("feedback", 32'(fb), 32'h1);
    want <= 2'b11;
    wdisp(1'b0);
    check("feedback", 32'(fb), 32'h0);
    rd(4'h8, 32'h303f, 32'h3003);
    $display("test power_up finished");
    bus(1'b1, 4'h4, 32'h0100_0300);
    bus(1'b1, 4'h0, 32'h33);
    pause(3);
    rd(4'h8, 32'hf300, 32'hc300);
    len = 1 + int'($urandom % 16);
    want <= 2'b10;
    pause(len);
    want <= 2'b11;
    pause(FP + 10);
    check("gate_brake", {28'h0, gate, brk}, 32'hf);
    $display("test pulse finished");
    want <= 2'b00;
    wdisp(1'b1);
    pause(2);
    check("brake", 32'(brk), 32'h0);
    bus(1'b1, 4'h0, 32'h3);
    fault <= 1'b1;
    pause(3);
    rd(4'h8, 32'h3_0f6c, 32'h3_0c6c);
    rd(4'hc, 32'h3, 32'h3);
    check("alarm", 32'(servo_alarm_out), 32'h0);
    check("gate_util", {28'h0, gate, util}, 32'h0);
    bus(1'b1, 4'hc, 32'h3);
    rd(4'hc, 32'h3, 32'h0);
    fault <= 1'b0;
    want <= 2'b11;
    pause(FP);
    rd(4'h8, 32'h3024, 32'h24);
    bus(1'b1, 4'h0, 32'h4);
    rd(4'h8, 32'h3024, 32'h24);
    bus(1'b1, 4'h0, 32'h8);
    pause(3);
    rd(4'h8, 32'h3024, 32'h3000);
    bus(1'b1, 4'h0, 32'h40);
    bus(1'b1, 4'h0, 32'h10);
    pause(3);
    check("util", 32'(util), 32'h0);
    bus(1'b1, 4'h0, 32'h80);
    bus(1'b1, 4'h0, 32'h20);
    pause(3);
    check("util", 32'(util), 32'h3);
    $display("test shutoff finished");
    for (int m = 0; m < 3; m++) begin
      st = 2'($urandom % 4);
      stopped <= st;
      ed = (m == 0) ? 2'b11 : ((m == 1) ? ~st : 2'b00);
      bus(1'b1, 4'h4, 32'(m));
      bus(1'b1, 4'h0, 32'h3);
      want <= 2'b00;
      wdisp(1'b1);
      pause(3);
      rd(4'h8, 32'h3_0000, {14'h0, ed, 16'h0});
      check("dyn_brake", 32'(dyn), 32'(ed));
      want <= 2'b11;
      wdisp(1'b0);
      bus(1'b1, 4'h0, 32'hc);
    end
    $display("test stop_modes finished");
    want <= 2'b10;
    pause(SP + FP + 20);
    check("alarm", 32'(servo_alarm_out), 32'h0);
    rd(4'h8, 32'h10, 32'h10);
    want <= 2'b11;
    pause(10);
    check("alarm_ready", {29'h0, servo_alarm_out, rdy}, 32'h4);
    rd(4'h2, 32'hffff_ffff, 32'h0);
    rd(4'h0, 32'hffff_ffff, 32'h0);
    check("fail", 32'(fail), 32'h0);
    $display("test skew_alarm finished");
    report_and_stop();
  end
endmodule : test_stm_monitor
bind stm_monitor stm_monitor_chk #(.FILT_CYC_P(FILT_CYC_P)) u_stm_monitor_chk (.i_clk,
  .i_rst_b, .i_shutoff_in_a_n, .i_shutoff_in_b_n, .o_shutoff_feedback_out,
  .o_brake_release_out, .o_servo_alarm_out, .o_servo_ready, .o_gate_enable,
  .o_shutoff_display);
`default_nettype wire
